// file: shared/udc_pkg.sv
package udc_pkg;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CFG_WR  = 8'hf0;
  localparam logic [7:0] CMD_CFG_RD  = 8'hf1;
  localparam logic [7:0] CMD_CNT_WR  = 8'hf2;
  localparam logic [7:0] CMD_CNT_RD  = 8'hf3;
  localparam logic [7:0] CMD_SOFT_RST = 8'hf6;
  localparam logic [7:0] CMD_NONE    = 8'h00;

  // bytes carried by each register command
  localparam logic [1:0] CMD_DATA_BYTES = 2'h2;

  // ----------------------------------------------------------------
  // dma configuration field positions
  // ----------------------------------------------------------------
  localparam int CFG_CNT_TERM_BIT   = 15;
  localparam int CFG_SHORT_TERM_BIT = 14;
  localparam int CFG_EP_SEL_LSB     = 4;
  localparam int CFG_EP_SEL_W       = 4;
  localparam int CFG_ENABLE_BIT     = 3;
  localparam int CFG_BURST_LSB      = 0;
  localparam int CFG_BURST_W        = 2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0]  EP_SEL_RST = 4'h0;
  localparam logic [1:0]  BURST_RST  = 2'h0;
  localparam logic [15:0] COUNT_RST  = 16'h0000;
  localparam logic [7:0]  BYTE_RST   = 8'h00;

  // ----------------------------------------------------------------
  // burst encodings and lengths in bytes
  // ----------------------------------------------------------------
  localparam logic [1:0] BURST_1  = 2'h0;
  localparam logic [1:0] BURST_4  = 2'h1;
  localparam logic [1:0] BURST_8  = 2'h2;
  localparam logic [1:0] BURST_16 = 2'h3;
  localparam logic [4:0] BURST_LEN_1  = 5'h01;
  localparam logic [4:0] BURST_LEN_4  = 5'h04;
  localparam logic [4:0] BURST_LEN_8  = 5'h08;
  localparam logic [4:0] BURST_LEN_16 = 5'h10;

  // ----------------------------------------------------------------
  // endpoint buffer addressing
  // ----------------------------------------------------------------
  localparam int          BUF_PTR_W     = 11;
  localparam logic [10:0] BUF_DATA_START = 11'h002;

  typedef enum logic [1:0] {
    UDC_IDLE,
    UDC_REQ,
    UDC_GAP
  } udc_dma_st_t;

endpackage : udc_pkg

// file: rtl/udc_sync.sv
`timescale 1ns/1ps
module udc_sync (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clk_en,
  // level crossing
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  // the first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : udc_sync

// file: rtl/udc_dma_cfg.sv
// Overview of operation
// - config register written by F0, read by F1, two data bytes each
// - usb bus reset clears only the enable bit of the configuration
// - counter termination bit set: end of transfer when working count hits zero
// - short packet bit set: short packet on out endpoint ends transfer
// - four bit endpoint field picks the buffer used by dma
// - writing enable one starts dma, writing zero ends it at once
// - reading enable bit shows live dma state, cleared after any stop
// - burst select 1, 4, 8 or 16 bytes, kept over bus reset
// - counter register written by F2, read by F3, sets transfer length
// - counter read returns bytes still to go, not programmed value
// - usb bus reset keeps the programmed counter value
// - each enable from idle reloads working counter from programmed value
// - counter high byte in bits 15..8, low byte in bits 7..0
// - command F6 resets the state like the hardware reset, but pins take their idle levels at once and the synchroniser is kept
// - in buffer is written with data for host, out buffer read
// - end of transfer pin low active when polarity bit is zero
// - request pin and acknowledge input follow their own polarity bits
// - acknowledge only mode when set, request/acknowledge handshake when clear
// - dma starts at third byte, skipping the packet length bytes
`timescale 1ns/1ps
module udc_dma_cfg
  import udc_pkg::*;
(
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst_n,
  input  wire logic                 clk_en,
  // command port from the processor interface
  input  wire logic                 cmd_wr,
  input  wire logic [7:0]           cmd_code,
  input  wire logic                 dat_wr,
  input  wire logic [7:0]           dat_wdata,
  input  wire logic                 dat_rd,
  output logic      [7:0]           rd_data,
  output logic                      rd_valid,
  // usb side events and endpoint status
  input  wire logic                 usb_bus_reset,
  input  wire logic                 ep_dir_out,
  input  wire logic                 buf_avail,
  input  wire logic                 short_pkt,
  // pin mode bits from the hardware configuration
  input  wire logic                 end_of_transfer_polarity,
  input  wire logic                 request_polarity,
  input  wire logic                 acknowledge_polarity,
  input  wire logic                 acknowledge_only_mode,
  // dma pins
  input  wire logic                 dma_acknowledge,
  output logic                      dma_request,
  output logic                      end_of_transfer,
  // endpoint buffer access
  output logic      [3:0]           dma_endpoint_select,
  output logic      [BUF_PTR_W-1:0] buf_ptr,
  output logic                      buf_wr,
  output logic                      buf_rd,
  output logic                      dma_busy
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]           cmd;
    logic [1:0]           idx;
    logic [7:0]           lo;
    logic                 counter_terminate_enable;
    logic                 short_packet_terminate;
    logic [3:0]           ep_sel;
    logic                 dma_transfer_enable;
    logic [1:0]           burst_length_select;
    logic [15:0]          prog_cnt;
    logic [15:0]          work_cnt;
    udc_dma_st_t          st;
    logic [4:0]           beat;
    logic [BUF_PTR_W-1:0] ptr;
    logic [7:0]           rdat;
    logic                 rvld;
    logic                 req_pin;
    logic                 eot_pin;
    logic                 bwr;
    logic                 brd;
    logic                 ack_prev;
  } udc_state_t;

  // the edge detector starts as if the acknowledge were active, so reset gives no false edge
  localparam udc_state_t ST_RST = '{
    cmd:                      CMD_NONE,
    idx:                      2'h0,
    lo:                       BYTE_RST,
    counter_terminate_enable: 1'b0,
    short_packet_terminate:   1'b0,
    ep_sel:                   EP_SEL_RST,
    dma_transfer_enable:      1'b0,
    burst_length_select:      BURST_RST,
    prog_cnt:                 COUNT_RST,
    work_cnt:                 COUNT_RST,
    st:                       UDC_IDLE,
    beat:                     5'h00,
    ptr:                      BUF_DATA_START,
    rdat:                     BYTE_RST,
    rvld:                     1'b0,
    req_pin:                  1'b0,
    eot_pin:                  1'b0,
    bwr:                      1'b0,
    brd:                      1'b0,
    ack_prev:                 1'b1
  };

  udc_state_t s_q;
  udc_state_t s_d;

  // ----------------------------------------------------------------
  // acknowledge pin crossing
  // ----------------------------------------------------------------
  logic ack_sync;

  // two flops keep a skewed acknowledge from reaching the engine half settled
  udc_sync u_ack_sync (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (dma_acknowledge),
    .sync_out (ack_sync)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // burst length in bytes for each select code
  function automatic logic [4:0] burst_bytes(input logic [1:0] sel);
    logic [4:0] n;
    n = BURST_LEN_1;
    unique case (sel)
      BURST_1:  n = BURST_LEN_1;
      BURST_4:  n = BURST_LEN_4;
      BURST_8:  n = BURST_LEN_8;
      BURST_16: n = BURST_LEN_16;
    endcase
    return n;
  endfunction : burst_bytes

  // reserved bits 13..8 and 2 are never stored
  function automatic logic [15:0] cfg_word(input udc_state_t s);
    logic [15:0] w;
    w = 16'h0000;
    w[CFG_CNT_TERM_BIT]                           = s.counter_terminate_enable;
    w[CFG_SHORT_TERM_BIT]                         = s.short_packet_terminate;
    w[CFG_EP_SEL_LSB +: CFG_EP_SEL_W]             = s.ep_sel;
    w[CFG_ENABLE_BIT]                             = s.dma_transfer_enable;
    w[CFG_BURST_LSB +: CFG_BURST_W]               = s.burst_length_select;
    return w;
  endfunction : cfg_word

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic        ack_act;
  logic        ack_edge;
  logic        byte_ok;
  logic        term_cnt;
  logic        term_short;
  logic [15:0] wword;
  logic [15:0] rword;
  logic        req_on;

  always_comb begin
    s_d        = s_q;
    s_d.rvld   = 1'b0;
    s_d.bwr    = 1'b0;
    s_d.brd    = 1'b0;
    s_d.eot_pin = 1'b0;
    wword      = {dat_wdata, s_q.lo};
    rword      = 16'h0000;

    // ----------------------------------------------------------------
    // acknowledge edge and end conditions
    // ----------------------------------------------------------------
    // one long acknowledge moves one byte only, hence the edge
    // acknowledge polarity
    ack_act    = acknowledge_polarity ? ack_sync : ~ack_sync;
    ack_edge   = ack_act & ~s_q.ack_prev;
    s_d.ack_prev = ack_act;

    term_cnt   = s_q.dma_transfer_enable && s_q.counter_terminate_enable &&
                 (s_q.work_cnt == 16'h0000);
    // only an out endpoint receives, so an in target never ends this way
    // short packet ends transfer
    term_short = s_q.dma_transfer_enable && s_q.short_packet_terminate &&
                 ep_dir_out && short_pkt;

    // no byte moves in the cycle that ends the transfer, so the count never overruns
    // handshake mode
    byte_ok    = s_q.dma_transfer_enable && ack_edge && buf_avail &&
                 !term_cnt && !term_short &&
                 (acknowledge_only_mode || s_q.st == UDC_REQ);

    // ----------------------------------------------------------------
    // dma engine
    // ----------------------------------------------------------------
    if (byte_ok) begin
      // in buffer filled, out buffer drained
      s_d.bwr  = ~ep_dir_out;
      s_d.brd  = ep_dir_out;
      s_d.ptr  = s_q.ptr + 11'h001;
      if (s_q.work_cnt != 16'h0000) begin
        s_d.work_cnt = s_q.work_cnt - 16'h0001;
      end
      if (s_q.beat + 5'h01 >= burst_bytes(s_q.burst_length_select)) begin
        s_d.beat = 5'h00;
        if (!acknowledge_only_mode) begin
          s_d.st = UDC_GAP;
        end
      end else begin
        s_d.beat = s_q.beat + 5'h01;
      end
    end

    unique case (s_q.st)
      UDC_IDLE: s_d.beat = 5'h00;
      UDC_REQ:  ;
      UDC_GAP:  if (!byte_ok) s_d.st = UDC_REQ;
      default:  s_d.st = UDC_IDLE;
    endcase

    if (term_cnt || term_short) begin
      s_d.dma_transfer_enable = 1'b0;
      s_d.st                  = UDC_IDLE;
      s_d.eot_pin             = 1'b1;
    end

    // ----------------------------------------------------------------
    // command port
    // ----------------------------------------------------------------
    // a lone first byte only parks in lo; nothing commits until the high byte
    if (cmd_wr) begin
      s_d.cmd = cmd_code;
      s_d.idx = 2'h0;
      if (cmd_code == CMD_SOFT_RST) begin
        s_d = ST_RST;
      end
    end else if (dat_wr && s_q.idx < CMD_DATA_BYTES) begin
      s_d.idx = s_q.idx + 2'h1;
      if (s_q.idx == 2'h0) begin
        s_d.lo = dat_wdata;
      end else if (s_q.cmd == CMD_CFG_WR) begin
        s_d.counter_terminate_enable = wword[CFG_CNT_TERM_BIT];
        s_d.short_packet_terminate   = wword[CFG_SHORT_TERM_BIT];
        s_d.ep_sel                   = wword[CFG_EP_SEL_LSB +: CFG_EP_SEL_W];
        s_d.burst_length_select      = wword[CFG_BURST_LSB +: CFG_BURST_W];
        if (wword[CFG_ENABLE_BIT]) begin
          // enable written again while running leaves the transfer untouched
          if (!s_q.dma_transfer_enable) begin
            s_d.dma_transfer_enable = 1'b1;
            s_d.st                  = UDC_REQ;
            s_d.beat                = 5'h00;
            s_d.ptr                 = BUF_DATA_START;
            s_d.work_cnt            = s_q.prog_cnt;
          end
        end else begin
          s_d.dma_transfer_enable = 1'b0;
          s_d.st                  = UDC_IDLE;
        end
      end else if (s_q.cmd == CMD_CNT_WR) begin
        s_d.prog_cnt = wword;
        // while idle the working count follows, so a read shows the new length
        if (!s_q.dma_transfer_enable) begin
          s_d.work_cnt = wword;
        end
      end
    end else if (dat_rd && s_q.idx < CMD_DATA_BYTES) begin
      s_d.idx  = s_q.idx + 2'h1;
      s_d.rvld = 1'b1;
      if (s_q.cmd == CMD_CFG_RD) begin
        rword = cfg_word(s_q);
      end else if (s_q.cmd == CMD_CNT_RD) begin
        rword = s_q.work_cnt;
      end
      s_d.rdat = (s_q.idx == 2'h0) ? rword[7:0] : rword[15:8];
    end

    // ----------------------------------------------------------------
    // usb bus reset and pin levels
    // ----------------------------------------------------------------
    // applied last so it wins over an enable written in the same cycle
    // bus reset drops enable only
    if (usb_bus_reset && !(cmd_wr && cmd_code == CMD_SOFT_RST)) begin
      s_d.dma_transfer_enable = 1'b0;
      s_d.st                  = UDC_IDLE;
    end

    // request only in handshake mode and only while data can move
    // it drops for a cycle after each burst so the controller sees a fresh edge
    req_on      = s_d.st == UDC_REQ && s_d.dma_transfer_enable &&
                  !acknowledge_only_mode && buf_avail;
    s_d.req_pin = request_polarity ? req_on : ~req_on;
    s_d.eot_pin = end_of_transfer_polarity ? s_d.eot_pin : ~s_d.eot_pin;
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // pins reset low; the polarity-correct idle level appears one edge later
  // clk_en low holds every field and the synchroniser, so acks are missed while frozen
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= ST_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // every pin comes straight from the state register
  assign rd_data             = s_q.rdat;
  assign rd_valid            = s_q.rvld;
  assign dma_request         = s_q.req_pin;
  assign end_of_transfer     = s_q.eot_pin;
  assign dma_endpoint_select = s_q.ep_sel;
  assign buf_ptr             = s_q.ptr;
  assign buf_wr              = s_q.bwr;
  assign buf_rd              = s_q.brd;
  assign dma_busy            = s_q.dma_transfer_enable;

endmodule : udc_dma_cfg

// file: test/udc_dma_cfg_monitor.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// port checker for the dma configuration block
// ----------------------------------------------------------------
module udc_dma_cfg_monitor
  import udc_pkg::*;
(
  // clock and reset
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  // command and event inputs
  input wire logic                 cmd_wr,
  input wire logic                 dat_wr,
  input wire logic                 dat_rd,
  input wire logic                 usb_bus_reset,
  input wire logic                 ep_dir_out,
  input wire logic                 end_of_transfer_polarity,
  input wire logic                 request_polarity,
  // observed outputs
  input wire logic                 rd_valid,
  input wire logic                 dma_request,
  input wire logic                 end_of_transfer,
  input wire logic [3:0]           dma_endpoint_select,
  input wire logic [BUF_PTR_W-1:0] buf_ptr,
  input wire logic                 buf_wr,
  input wire logic                 buf_rd,
  input wire logic                 dma_busy
);
  // pins read zero straight out of reset whatever the polarity, so skip that edge
  logic live_q;
  logic eot_on;
  assign eot_on = end_of_transfer == end_of_transfer_polarity;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      live_q <= 1'b0;
    end else begin
      live_q <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_rd_answer;
    rd_valid |-> $past(dat_rd) && !$past(cmd_wr) && !$past(dat_wr);
  endproperty
  a_rd_answer:
    assert property (p_rd_answer) else $error("read answer without read stroke");
  property p_bus_reset_stop;
    usb_bus_reset |=> !dma_busy;
  endproperty
  a_bus_reset_stop:
    assert property (p_bus_reset_stop) else $error("dma still enabled after bus reset");
  property p_busy_start;
    $rose(dma_busy) |-> $past(dat_wr) && buf_ptr == BUF_DATA_START;
  endproperty
  a_busy_start:
    assert property (p_busy_start) else $error("dma start without write or bad pointer");
  property p_strobe_dir;
    (buf_wr || buf_rd) |-> buf_rd == $past(ep_dir_out) && !(buf_wr && buf_rd);
  endproperty
  a_strobe_dir:
    assert property (p_strobe_dir) else $error("buffer strobe against direction");
  property p_byte_step;
    (buf_wr || buf_rd) |-> $past(dma_busy) && buf_ptr == $past(buf_ptr) + 11'h001;
  endproperty
  a_byte_step:
    assert property (p_byte_step) else $error("byte move without step of pointer");
  property p_eot_pulse;
    live_q && eot_on |=> !eot_on;
  endproperty
  a_eot_pulse:
    assert property (p_eot_pulse) else $error("end of transfer longer than one cycle");
  property p_eot_stops;
    live_q && eot_on && $stable(end_of_transfer_polarity) |-> !dma_busy;
  endproperty
  a_eot_stops:
    assert property (p_eot_stops) else $error("end of transfer left dma enabled");
  property p_req_idle;
    live_q && !$past(cmd_wr) && $stable(request_polarity)
      && dma_request == request_polarity |-> dma_busy || $past(dma_busy);
  endproperty
  a_req_idle:
    assert property (p_req_idle) else $error("request active while disabled");
  property p_ep_hold;
    !$stable(dma_endpoint_select) |-> $past(dat_wr) || $past(cmd_wr);
  endproperty
  a_ep_hold:
    assert property (p_ep_hold) else $error("endpoint select moved without write");
endmodule : udc_dma_cfg_monitor

bind udc_dma_cfg udc_dma_cfg_monitor mon_u (.clk_sys, .rst_n, .cmd_wr, .dat_wr, .dat_rd,
  .usb_bus_reset, .ep_dir_out, .end_of_transfer_polarity, .request_polarity, .rd_valid,
  .dma_request, .end_of_transfer, .dma_endpoint_select, .buf_ptr, .buf_wr, .buf_rd, .dma_busy);

// file: test/udc_dma_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// external dma controller: one byte per acknowledge pulse
// ----------------------------------------------------------------
module udc_dma_host_model (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // pin setup and pacing
  input  wire logic request_polarity,
  input  wire logic acknowledge_polarity,
  input  wire logic acknowledge_only_mode,
  input  wire logic stall,
  // dma pins
  input  wire logic dma_request,
  output logic      dma_acknowledge
);
  logic [2:0] phase_q;
  // ack only while requested, unless ack-only mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 3'h0;
    end else if (phase_q != 3'h0) begin
      phase_q <= (phase_q == 3'h5) ? 3'h0 : phase_q + 3'h1;
    end else if (!stall && (acknowledge_only_mode || dma_request == request_polarity)) begin
      phase_q <= 3'h1;
    end
  end
  // three cycles active then three idle, so the synchroniser sees every edge
  assign dma_acknowledge = (phase_q != 3'h0 && phase_q < 3'h4) ? acknowledge_polarity
                                                               : ~acknowledge_polarity;
endmodule : udc_dma_host_model

// file: test/udc_dma_cfg_tb_top.sv
`timescale 1ns/1ps
module udc_dma_cfg_tb_top;
  import udc_pkg::*;
  logic clk_sys = 0, rst_n = 0, clk_en = 1, cmd_wr = 0, dat_wr = 0, dat_rd = 0;
  logic usb_bus_reset = 0, ep_dir_out = 0, buf_avail = 1, short_pkt = 0, stall = 0;
  logic end_of_transfer_polarity = 1, request_polarity = 1, acknowledge_polarity = 1;
  logic acknowledge_only_mode = 0, dma_acknowledge, dma_request, end_of_transfer;
  logic [7:0] cmd_code = 8'h00, dat_wdata = 8'h00, rd_data;
  logic rd_valid, buf_wr, buf_rd, dma_busy, req_q = 0;
  logic [3:0] dma_endpoint_select;
  logic [BUF_PTR_W-1:0] buf_ptr;
  logic [15:0] v, w0, r0, e0;
  logic [4:0] blen [4] = '{BURST_LEN_1, BURST_LEN_4, BURST_LEN_8, BURST_LEN_16};
  int num_errors = 0, comparisons = 0;
  logic [15:0] wrc = 0, rdc = 0, eotc = 0, runs = 0;
  always #2 clk_sys = ~clk_sys;
  udc_dma_cfg dut_u (.clk_sys, .rst_n, .clk_en, .cmd_wr, .cmd_code, .dat_wr, .dat_wdata,
    .dat_rd, .rd_data, .rd_valid, .usb_bus_reset, .ep_dir_out, .buf_avail, .short_pkt,
    .end_of_transfer_polarity, .request_polarity, .acknowledge_polarity,
    .acknowledge_only_mode, .dma_acknowledge, .dma_request, .end_of_transfer,
    .dma_endpoint_select, .buf_ptr, .buf_wr, .buf_rd, .dma_busy);
  udc_dma_host_model host_u (.clk_sys, .rst_n, .request_polarity, .acknowledge_polarity,
    .acknowledge_only_mode, .stall, .dma_request, .dma_acknowledge);
  // sampled on the falling edge, away from the design's updates
  always @(negedge clk_sys) begin
    if (buf_wr === 1'b1) wrc++;
    if (buf_rd === 1'b1) rdc++;
    if (rst_n && end_of_transfer === end_of_transfer_polarity) eotc++;
    if (!req_q && dma_request === request_polarity && dma_busy === 1'b1) runs++;
    req_q = (dma_request === request_polarity);
  end
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic cmd(input logic [7:0] c);
    @(posedge clk_sys) cmd_wr <= 1'b1;
    cmd_code <= c;
    @(posedge clk_sys) cmd_wr <= 1'b0;
  endtask : cmd
  task automatic wr16(input logic [7:0] c, input logic [15:0] d);
    cmd(c);
    dat_wr <= 1'b1;
    dat_wdata <= d[7:0];
    @(posedge clk_sys) dat_wdata <= d[15:8];
    @(posedge clk_sys) dat_wr <= 1'b0;
  endtask : wr16
  // low byte answers the first stroke, high byte the second
  task automatic rd16(input logic [7:0] c, output logic [15:0] d);
    cmd(c);
    dat_rd <= 1'b1;
    @(posedge clk_sys) #1 d[7:0] = rd_data;
    @(posedge clk_sys) dat_rd <= 1'b0;
    #1 d[15:8] = rd_data;
  endtask : rd16
  // falling edges, so busy has settled and the byte and end counters are up to date
  task automatic wait_idle();
    @(negedge clk_sys);
    for (int i = 0; i < 3000 && dma_busy !== 1'b0; i++) @(negedge clk_sys);
    #1 chk("idle", 16'h0000, {15'h0000, dma_busy});
  endtask : wait_idle
  task automatic wait_bytes(input logic [15:0] n);
    for (int i = 0; i < 500 && (wrc + rdc - w0) < n; i++) @(posedge clk_sys);
    chk("moved", 16'h0001, {15'h0000, (wrc + rdc - w0) >= n});
  endtask : wait_bytes
  task automatic conclude();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  initial begin
    #80000;
    num_errors++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd16(CMD_CFG_RD, v); chk("cfg reset", 16'h0000, v);
    rd16(CMD_CNT_RD, v); chk("cnt reset", 16'h0000, v);
    wr16(CMD_CNT_WR, 16'h1234);
    rd16(CMD_CNT_RD, v); chk("cnt bytes", 16'h1234, v);
    wr16(CMD_CFG_WR, 16'h3f44);
    rd16(CMD_CFG_RD, v); chk("reserved", 16'h0040, v);
    chk("ep select", 16'h0004, {12'h000, dma_endpoint_select});
    for (int b = 0; b < 4; b++) begin
      request_polarity <= b[0];
      acknowledge_polarity <= b[1];
      end_of_transfer_polarity <= ~b[0];
      acknowledge_only_mode <= (b == 3);
      repeat (4) @(posedge clk_sys);
      {w0, e0, r0} = {wrc, eotc, runs};
      wr16(CMD_CNT_WR, 16'h0010);
      // in endpoint target, so short packet stays clear
      wr16(CMD_CFG_WR, 16'h8018 | 16'(b));
      wait_idle();
      chk("bytes", 16'h0010, wrc - w0);
      chk("eot", 16'h0001, eotc - e0);
      if (b != 3) chk("bursts", 16'(16 / blen[b]), runs - r0);
      rd16(CMD_CNT_RD, v); chk("remaining", 16'h0000, v);
      rd16(CMD_CFG_RD, v); chk("cfg after", 16'h8010 | 16'(b), v);
    end
    w0 = wrc + rdc;
    wr16(CMD_CNT_WR, 16'h0100);
    wr16(CMD_CFG_WR, 16'h802a);
    wait_bytes(16'h0003);
    @(posedge clk_sys) usb_bus_reset <= 1'b1;
    stall <= 1'b1;
    @(posedge clk_sys) usb_bus_reset <= 1'b0;
    rd16(CMD_CFG_RD, v); chk("cfg bus reset", 16'h8022, v);
    repeat (10) @(posedge clk_sys);
    wr16(CMD_CFG_WR, 16'h802a);
    rd16(CMD_CNT_RD, v); chk("reload", 16'h0100, v);
    // clock enable low must hold the enable bit against a stop write
    @(posedge clk_sys) clk_en <= 1'b0;
    wr16(CMD_CFG_WR, 16'h0022);
    #1 chk("frozen", 16'h0001, {15'h0000, dma_busy});
    @(posedge clk_sys) clk_en <= 1'b1;
    wr16(CMD_CFG_WR, 16'h0022);
    #1 chk("forced end", 16'h0000, {15'h0000, dma_busy});
    rd16(CMD_CFG_RD, v); chk("cfg stop", 16'h0022, v);
    stall <= 1'b0;
    ep_dir_out <= 1'b1;
    {w0, e0} = {wrc + rdc, eotc};
    wr16(CMD_CNT_WR, 16'h0002);
    wr16(CMD_CFG_WR, 16'h4018);
    wait_bytes(16'h0004);
    #1 chk("runs on", 16'h0001, {15'h0000, dma_busy});
    rd16(CMD_CNT_RD, v); chk("held zero", 16'h0000, v);
    @(posedge clk_sys) short_pkt <= 1'b1;
    @(posedge clk_sys) short_pkt <= 1'b0;
    wait_idle();
    chk("short eot", 16'h0001, eotc - e0);
    end_of_transfer_polarity <= 1'b1;
    wr16(CMD_CFG_WR, 16'h80f1);
    cmd(CMD_SOFT_RST);
    rd16(CMD_CFG_RD, v); chk("soft cfg", 16'h0000, v);
    rd16(CMD_CNT_RD, v); chk("soft cnt", 16'h0000, v);
    conclude();
  end
endmodule : udc_dma_cfg_tb_top
